// [rtl/cid_decode.sv]
// Execute logic for interrupt, watchdog and power-down control words
module cid_decode #(
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_WDT_ARM =
      cid_pkg::CODE_WDT_ARM_DFLT,
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_WDT_RST =
      cid_pkg::CODE_WDT_RST_DFLT,
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_PD_A    =
      cid_pkg::CODE_PD_A_DFLT,
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_PD_B    =
      cid_pkg::CODE_PD_B_DFLT
) (
   input  wire logic                        CLK,
   input  wire logic                        RST_N,
   input  wire logic                        EXEC_EN,
   input  wire logic [cid_pkg::INSTR_W-1:0] INSTR,
   output logic                             GLOBAL_IRQ_ENABLE_FLAG,
   output logic                             IRQ_ACCEPT_EN,
   output logic                             WDT_RESTART,
   output logic                             WDT_STOP_REQ,
   output logic                             PD_VALID,
   output logic                             PD_SEL_B,
   output logic                             CTRL_DONE,
   output logic                             CARRY_HOLD,
   output logic                             SKIP_NEXT
);
   import cid_pkg::*;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic is_irq_disable;
   logic is_irq_enable;
   logic is_wdt_arm;
   logic is_wdt_rst;
   logic is_pd_arm;
   logic is_pd_a;
   logic is_pd_b;
   logic is_ctrl;

   cid_opdec #(
      .CODE_WDT_ARM (CODE_WDT_ARM),
      .CODE_WDT_RST (CODE_WDT_RST),
      .CODE_PD_A    (CODE_PD_A),
      .CODE_PD_B    (CODE_PD_B)
   ) cid_opdec_i (
      .instr          (INSTR),
      .is_irq_disable (is_irq_disable),
      .is_irq_enable  (is_irq_enable),
      .is_wdt_arm     (is_wdt_arm),
      .is_wdt_rst     (is_wdt_rst),
      .is_pd_arm      (is_pd_arm),
      .is_pd_a        (is_pd_a),
      .is_pd_b        (is_pd_b),
      .is_ctrl        (is_ctrl)
   );

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic irq_flag;
      logic accept;
      logic wdt_arm;
      logic pd_arm;
      logic wdt_restart;
      logic wdt_stop;
      logic pd_valid;
      logic pd_sel_b;
      logic done;
      logic carry_hold;
      logic skip;
   } cid_state_s;

   cid_state_s st;
   cid_state_s next_st;

   // Helper terms, also read by the checks below
   logic exec_irq_off;
   logic exec_irq_on;
   logic exec_ctrl;
   logic exec_wdt_arm;
   logic exec_wdt_rst;
   logic stop_cause;
   logic pd_any;
   logic pd_follow;

   assign exec_irq_off = EXEC_EN & is_irq_disable;
   assign exec_irq_on  = EXEC_EN & is_irq_enable;
   assign exec_ctrl    = EXEC_EN & is_ctrl;
   assign exec_wdt_arm = EXEC_EN & is_wdt_arm;
   assign exec_wdt_rst = EXEC_EN & is_wdt_rst;
   assign stop_cause   = exec_wdt_rst & st.wdt_arm;
   assign pd_any       = is_pd_a | is_pd_b;
   assign pd_follow    = EXEC_EN & pd_any & st.pd_arm;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st             = st;
      // Pulses last one clock
      next_st.wdt_restart = RST_PULSE;
      next_st.wdt_stop    = RST_PULSE;
      next_st.pd_valid    = RST_PULSE;
      next_st.done        = RST_PULSE;
      next_st.carry_hold  = RST_PULSE;
      next_st.skip        = RST_PULSE;

      if (EXEC_EN) begin
         // Acceptance samples the flag before this word changes it,
         // so a flag change is seen one machine cycle late
         next_st.accept = st.irq_flag; // [RULE2] [RULE4]

         if (is_irq_disable) begin
            next_st.irq_flag = 1'b0; // [RULE1]
         end else if (is_irq_enable) begin
            next_st.irq_flag = 1'b1; // [RULE3]
         end

         // Arm is only a permission; it never stops anything itself
         if (is_wdt_arm) begin
            next_st.wdt_arm = 1'b1; // [RULE5]
         end

         if (is_wdt_rst) begin
            next_st.wdt_restart = 1'b1;
            if (st.wdt_arm) begin
               next_st.wdt_stop = 1'b1; // [RULE6]
               next_st.wdt_arm  = 1'b0;
            end
         end

         // Any word other than the arm itself drops the permission,
         // so only the very next word can be a valid power-down
         next_st.pd_arm = is_pd_arm; // [RULE7]
         if (pd_follow) begin
            next_st.pd_valid = 1'b1; // [RULE7]
            next_st.pd_sel_b = is_pd_b;
         end

         // Single cycle, carry untouched, never a skip
         if (is_ctrl) begin
            next_st.done       = 1'b1; // [RULE8]
            next_st.carry_hold = 1'b1; // [RULE8]
            next_st.skip       = 1'b0; // [RULE8]
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st             <= '0;
         st.irq_flag    <= RST_IRQ_FLAG;
         st.accept      <= RST_ACCEPT;
         st.wdt_arm     <= RST_WDT_ARM;
         st.pd_arm      <= RST_PD_ARM;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign GLOBAL_IRQ_ENABLE_FLAG = st.irq_flag;
   assign IRQ_ACCEPT_EN          = st.accept;
   assign WDT_RESTART            = st.wdt_restart;
   assign WDT_STOP_REQ           = st.wdt_stop;
   assign PD_VALID               = st.pd_valid;
   assign PD_SEL_B               = st.pd_sel_b;
   assign CTRL_DONE              = st.done;
   assign CARRY_HOLD             = st.carry_hold;
   assign SKIP_NEXT              = st.skip;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_off_clears_flag: assert property ( // [RULE1]
      @(posedge CLK) disable iff (!RST_N)
      exec_irq_off |=> !GLOBAL_IRQ_ENABLE_FLAG)
      else $error("Disable word did not clear the flag");

   a_off_accept_lag: assert property ( // [RULE2]
      @(posedge CLK) disable iff (!RST_N)
      (exec_irq_off && GLOBAL_IRQ_ENABLE_FLAG) |=>
         (IRQ_ACCEPT_EN && !GLOBAL_IRQ_ENABLE_FLAG))
      else $error("Acceptance dropped without the one cycle lag");

   a_on_sets_flag: assert property ( // [RULE3]
      @(posedge CLK) disable iff (!RST_N)
      exec_irq_on |=> GLOBAL_IRQ_ENABLE_FLAG)
      else $error("Enable word did not set the flag");

   a_on_accept_lag: assert property ( // [RULE4]
      @(posedge CLK) disable iff (!RST_N)
      (exec_irq_on && !GLOBAL_IRQ_ENABLE_FLAG) |=>
         (!IRQ_ACCEPT_EN && GLOBAL_IRQ_ENABLE_FLAG)
         ##1 (IRQ_ACCEPT_EN || !$past(EXEC_EN) ||
              !$past(GLOBAL_IRQ_ENABLE_FLAG)))
      else $error("Acceptance rose without the one cycle lag");

   a_accept_follows: assert property ( // [RULE2] [RULE4]
      @(posedge CLK) disable iff (!RST_N)
      EXEC_EN |=> (IRQ_ACCEPT_EN == $past(GLOBAL_IRQ_ENABLE_FLAG)))
      else $error("Acceptance does not trail the flag");

   a_accept_stable: assert property ( // [RULE2] [RULE4]
      @(posedge CLK) disable iff (!RST_N)
      !EXEC_EN |=> $stable(IRQ_ACCEPT_EN))
      else $error("Acceptance moved outside a machine cycle");

   a_arm_no_stop: assert property ( // [RULE5]
      @(posedge CLK) disable iff (!RST_N)
      exec_wdt_arm |=> !WDT_STOP_REQ)
      else $error("Watchdog arm stopped the watchdog by itself");

   a_wdt_stop_req: assert property ( // [RULE6]
      @(posedge CLK) disable iff (!RST_N)
      stop_cause |=> (WDT_STOP_REQ && WDT_RESTART) ##1 !WDT_STOP_REQ)
      else $error("Armed restart gave no one cycle stop request");

   a_wdt_stop_why: assert property ( // [RULE6]
      @(posedge CLK) disable iff (!RST_N)
      WDT_STOP_REQ |-> $past(stop_cause))
      else $error("Stop request without an armed restart");

   a_pd_follow: assert property ( // [RULE7]
      @(posedge CLK) disable iff (!RST_N)
      pd_follow |=> (PD_VALID && (PD_SEL_B == $past(is_pd_b))))
      else $error("Power-down after arm was not made valid");

   a_pd_reject: assert property ( // [RULE7]
      @(posedge CLK) disable iff (!RST_N)
      PD_VALID |-> $past(pd_follow))
      else $error("Power-down made valid without a preceding arm");

   a_ctrl_single: assert property ( // [RULE8]
      @(posedge CLK) disable iff (!RST_N)
      exec_ctrl |=>
         (CTRL_DONE && CARRY_HOLD && !SKIP_NEXT) ##1
         (CTRL_DONE == $past(exec_ctrl)))
      else $error("Control word not one cycle, carry kept, no skip");

endmodule // cid_decode

// [rtl/cid_pkg.sv]
// Constants and helpers for the control instruction decoder
//
// Operation
// (RULE1) Disable instruction clears the interrupt enable flag
// (RULE2) Interrupt acceptance turns off one cycle later
// (RULE3) Enable instruction sets the interrupt enable flag
// (RULE4) Interrupt acceptance turns on one cycle later
// (RULE5) Watchdog arm only permits a later stop
// (RULE6) Restart after arm stops the watchdog
// (RULE7) Power-down valid only right after its arm
// (RULE8) One word, one cycle, carry kept, no skip
package cid_pkg;

   // ------------------------------------------------------------
   // Instruction word
   // ------------------------------------------------------------
   localparam int INSTR_W = 10;

   // ------------------------------------------------------------
   // Opcodes with a fixed encoding
   // ------------------------------------------------------------
   localparam logic [INSTR_W-1:0] CODE_IRQ_DISABLE = 10'h004;
   localparam logic [INSTR_W-1:0] CODE_IRQ_ENABLE  = 10'h005;
   localparam logic [INSTR_W-1:0] CODE_PD_ARM      = 10'h05b;

   // ------------------------------------------------------------
   // Defaults for opcodes set per core (arbitrary values)
   // ------------------------------------------------------------
   localparam logic [INSTR_W-1:0] CODE_WDT_ARM_DFLT = 10'h3f0;
   localparam logic [INSTR_W-1:0] CODE_WDT_RST_DFLT = 10'h3f1;
   localparam logic [INSTR_W-1:0] CODE_PD_A_DFLT    = 10'h3f2;
   localparam logic [INSTR_W-1:0] CODE_PD_B_DFLT    = 10'h3f3;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic RST_IRQ_FLAG = 1'b0;
   localparam logic RST_ACCEPT   = 1'b0;
   localparam logic RST_WDT_ARM  = 1'b0;
   localparam logic RST_PD_ARM   = 1'b0;
   localparam logic RST_PULSE    = 1'b0;

   // Exact opcode compare
   function automatic logic cid_match(
      input logic [INSTR_W-1:0] word,
      input logic [INSTR_W-1:0] code
   );
      return word == code;
   endfunction

endpackage : cid_pkg

// [rtl/cid_opdec.sv]
// Opcode decoder for the control instructions
module cid_opdec
   import cid_pkg::*;
#(
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_WDT_ARM =
      cid_pkg::CODE_WDT_ARM_DFLT,
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_WDT_RST =
      cid_pkg::CODE_WDT_RST_DFLT,
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_PD_A    =
      cid_pkg::CODE_PD_A_DFLT,
   parameter logic [cid_pkg::INSTR_W-1:0] CODE_PD_B    =
      cid_pkg::CODE_PD_B_DFLT
) (
   input  wire logic [cid_pkg::INSTR_W-1:0] instr,
   output logic                             is_irq_disable,
   output logic                             is_irq_enable,
   output logic                             is_wdt_arm,
   output logic                             is_wdt_rst,
   output logic                             is_pd_arm,
   output logic                             is_pd_a,
   output logic                             is_pd_b,
   output logic                             is_ctrl
);

   always_comb begin
      is_irq_disable = cid_match(instr, CODE_IRQ_DISABLE);
      is_irq_enable  = cid_match(instr, CODE_IRQ_ENABLE);
      is_wdt_arm     = cid_match(instr, CODE_WDT_ARM);
      is_wdt_rst     = cid_match(instr, CODE_WDT_RST);
      is_pd_arm      = cid_match(instr, CODE_PD_ARM);
      is_pd_a        = cid_match(instr, CODE_PD_A);
      is_pd_b        = cid_match(instr, CODE_PD_B);
      is_ctrl        = is_irq_disable | is_irq_enable | is_wdt_arm |
                       is_wdt_rst | is_pd_arm | is_pd_a | is_pd_b;
   end

endmodule // cid_opdec

// [test/cid_decode_bench.sv]
// Self-checking bench for the control instruction decoder
`define CHK(GOT, EXP) \
   begin \
      n_checks++; \
      if ((GOT) !== (EXP)) begin \
         fails++; \
         $display("CHECK FAILED t=%0t got %b exp %b", $time, GOT, EXP); \
      end \
   end

module cid_decode_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cid_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic               clk;
   logic               rst_n;
   logic               exec_en;
   logic [INSTR_W-1:0] instr;
   logic               flag;
   logic               accept;
   logic               wdt_restart;
   logic               wdt_stop;
   logic               pd_valid;
   logic               pd_sel_b;
   logic               done;
   logic               carry_hold;
   logic               skip_next;
   logic [8:0]         outs;
   int                 fails;
   int                 n_checks;

   // Order: flag, accept | restart, stop | pd valid, sel b | done, carry, skip
   assign outs = {flag, accept, wdt_restart, wdt_stop, pd_valid, pd_sel_b,
                  done, carry_hold, skip_next};

   cid_decode cid_decode_i (
      .CLK                    (clk),
      .RST_N                  (rst_n),
      .EXEC_EN                (exec_en),
      .INSTR                  (instr),
      .GLOBAL_IRQ_ENABLE_FLAG (flag),
      .IRQ_ACCEPT_EN          (accept),
      .WDT_RESTART            (wdt_restart),
      .WDT_STOP_REQ           (wdt_stop),
      .PD_VALID               (pd_valid),
      .PD_SEL_B               (pd_sel_b),
      .CTRL_DONE              (done),
      .CARRY_HOLD             (carry_hold),
      .SKIP_NEXT              (skip_next)
   );

   // ------------------------------------------------------------
   // Clock, closing and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // About 35 cycles of work; generous margin
   initial begin
      #(400 * 20);
      fails++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Stepping: entered at a falling edge, returns at the next one
   // ------------------------------------------------------------
   task automatic ex(input logic en, input logic [INSTR_W-1:0] w);
      exec_en = en;
      instr   = w;
      @(posedge clk);
      @(negedge clk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_irq();
      ex(1'b1, CODE_IRQ_ENABLE);
      `CHK(outs, 9'b10_00_00_110)
      // Idle clock is no machine cycle, acceptance must wait
      ex(1'b0, 10'h000);
      `CHK(outs, 9'b10_00_00_000)
      ex(1'b1, 10'h000);
      `CHK(outs, 9'b11_00_00_000)
      ex(1'b1, CODE_IRQ_DISABLE);
      `CHK(outs, 9'b01_00_00_110)
      ex(1'b1, CODE_IRQ_DISABLE);
      `CHK(outs, 9'b00_00_00_110)
   endtask

   task automatic t_wdt();
      ex(1'b1, CODE_WDT_RST_DFLT);
      `CHK(outs, 9'b00_10_00_110)
      ex(1'b1, CODE_WDT_ARM_DFLT);
      `CHK(outs, 9'b00_00_00_110)
      ex(1'b1, 10'h000);
      `CHK(outs, 9'b00_00_00_000)
      ex(1'b1, CODE_WDT_RST_DFLT);
      `CHK(outs, 9'b00_11_00_110)
      // Arm was used up by the previous restart
      ex(1'b1, CODE_WDT_RST_DFLT);
      `CHK(outs, 9'b00_10_00_110)
   endtask

   task automatic t_pd();
      ex(1'b1, CODE_PD_ARM);
      `CHK(outs, 9'b00_00_00_110)
      ex(1'b1, CODE_PD_B_DFLT);
      `CHK(outs, 9'b00_00_11_110)
      ex(1'b1, CODE_PD_A_DFLT);
      `CHK(outs, 9'b00_00_01_110)
      ex(1'b1, CODE_PD_ARM);
      ex(1'b1, 10'h000);
      ex(1'b1, CODE_PD_A_DFLT);
      `CHK(outs, 9'b00_00_01_110)
      ex(1'b1, CODE_PD_ARM);
      ex(1'b1, CODE_PD_ARM);
      ex(1'b1, CODE_PD_A_DFLT);
      `CHK(outs, 9'b00_00_10_110)
   endtask

   task automatic t_reset();
      ex(1'b1, CODE_WDT_ARM_DFLT);
      ex(1'b1, CODE_IRQ_ENABLE);
      rst_n = 1'b0;
      ex(1'b1, CODE_IRQ_ENABLE);
      `CHK(outs, 9'b00_00_00_000)
      rst_n = 1'b1;
      ex(1'b0, 10'h000);
      `CHK(outs, 9'b00_00_00_000)
      // Reset must have dropped the stop arm
      ex(1'b1, CODE_WDT_RST_DFLT);
      `CHK(outs, 9'b00_10_00_110)
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      fails    = 0;
      n_checks = 0;
      rst_n    = 1'b0;
      exec_en  = 1'b0;
      instr    = 10'h000;
      repeat (10) @(negedge clk);
      `CHK(outs, 9'b00_00_00_000)
      rst_n = 1'b1;
      ex(1'b0, 10'h000);
      `CHK(outs, 9'b00_00_00_000)
      t_irq();
      t_wdt();
      t_pd();
      t_reset();
      report_and_stop();
   end

endmodule // cid_decode_bench
